// file: fsag_pkg.sv
// Constants, types and the two-stage synchroniser of the flash access guard.
// Assumes a single 20 MHz core clock and a plain address/strobe register port.
// Operation
// [R01] Security byte starts unprotected at all ones
// [R02] Security byte writes may only raise level
// [R03] Level one refuses flash, status, vector writes
// [R04] Level two refuses all flash reads, writes
// [R05] Only full chip erase lowers security level
// [R06] Memory class: free, read-only, then none
// [R07] Security byte: free, level-two write, read-only
// [R08] Block erase level zero; chip erase always
// [R09] Lock bits active low; first blocks programming
// [R10] Second lock bit also blocks in-system verify
// [R11] Programmer locks only after verifying contents
// [R12] Internal flash fills lowest 16K or 32K
// [R13] Pin high: internal until counter passes top
// [R14] Pin low: every fetch goes external
// [R15] Level and locks survive every reset; here only rst keeps them, por reloads them blank
package fsag_pkg;

  // Register byte offsets
  localparam logic [7:0] REG_CMD    = 8'h00;  // Command issue / echo
  localparam logic [7:0] REG_RESULT = 8'h04;  // Outcome of last command
  localparam logic [7:0] REG_STATE  = 8'h08;  // Security and fetch state

  // Command register fields
  localparam int CMD_OP_LSB   = 0;   // Operation field
  localparam int CMD_TGT_LSB  = 3;   // Target field
  localparam int CMD_ISP_BIT  = 6;   // Issued over in-system port
  localparam int CMD_DATA_LSB = 8;   // Data byte

  // Result register fields
  localparam int RES_ANS_LSB  = 0;   // Answer character
  localparam int RES_GRANT    = 8;   // Last command granted
  localparam int RES_REFUSE   = 9;   // Last command refused
  localparam int RES_BUSY     = 10;  // Engine busy
  localparam int RES_OVERRUN  = 11;  // Command dropped while busy
  localparam int RES_DATA_LSB = 16;  // Read value

  // State register fields
  localparam int STA_SSB_LSB  = 0;   // Security byte
  localparam int STA_LOCK_LSB = 8;   // Lock bits, first at low bit
  localparam int STA_LVL_LSB  = 10;  // Decoded level
  localparam int STA_FEXT     = 12;  // Fetch goes external
  localparam int STA_PIN      = 13;  // Synchronised access pin

  // Security byte encodings
  localparam logic [7:0] SSB_LEVEL0 = 8'hFF;  // No security
  localparam logic [7:0] SSB_LEVEL1 = 8'hFE;  // Write security
  localparam logic [7:0] SSB_LEVEL2 = 8'hFC;  // Read and write security

  // Lock bits unprogrammed, both ones
  localparam logic [1:0] LOCK_BLANK = 2'h3;

  // Bootloader answer characters
  localparam logic [7:0] ANS_OK    = 8'h00;  // Granted
  localparam logic [7:0] ANS_PROT  = 8'h50;  // Character P
  localparam logic [7:0] ANS_LOCK  = 8'h4C;  // Character L

  // Program space
  localparam logic [15:0] FLASH_TOP_16K = 16'h3FFF;  // Small variant top
  localparam logic [15:0] FLASH_TOP_32K = 16'h7FFF;  // Large variant top

  // Security levels
  typedef enum logic [1:0]
  {
    LVL_0 = 2'h0,
    LVL_1 = 2'h1,
    LVL_2 = 2'h2
  } fsag_level_t;

  // Operations
  typedef enum logic [2:0]
  {
    OP_READ        = 3'h0,
    OP_WRITE       = 3'h1,
    OP_BLOCK_ERASE = 3'h2,
    OP_CHIP_ERASE  = 3'h3,
    OP_BLANK_CHECK = 3'h4
  } fsag_op_t;

  // Targets
  typedef enum logic [2:0]
  {
    TGT_FLASH     = 3'h0,
    TGT_FUSE      = 3'h1,
    TGT_BOOT_STAT = 3'h2,
    TGT_BOOT_VEC  = 3'h3,
    TGT_SSB       = 3'h4,
    TGT_MANUF     = 3'h5,
    TGT_BOOT_INFO = 3'h6,
    TGT_LOCK      = 3'h7
  } fsag_target_t;

  // Command engine states, Gray along the path
  typedef enum logic [1:0]
  {
    ST_IDLE   = 2'h0,
    ST_CHECK  = 2'h1,
    ST_ANSWER = 2'h3
  } fsag_state_t;

  // One captured request
  typedef struct packed
  {
    fsag_op_t     op;      // Operation
    fsag_target_t target;  // Target
    logic         isp;     // From in-system port
    logic [7:0]   data;    // Data byte
  } fsag_req_t;

endpackage

`timescale 1ns/1ps

// Two flip-flop synchroniser for levels from outside the clock domain
module fsag_sync
#(
  parameter int W = 1      // Width
)
(
  input  wire logic         clk,  // Core clock
  input  wire logic         rst,  // Synchronous reset
  input  wire logic [W-1:0] d,    // Asynchronous level
  output logic      [W-1:0] q     // Synchronised level
);

  logic [W-1:0] meta;  // First stage, read only by second

  // Two stages in series
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta <= '0;
      q    <= '0;
    end
    else
    begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

// file: fsag_guard.sv
// Flash security access guard: checks each requested access against the
// security byte and the two lock bits, and selects the instruction fetch source.
// Assumes a register master on the same clock and an asynchronous access pin.
//
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ps

module fsag_guard
  import fsag_pkg::*;
#(
  parameter bit FLASH_32K = 1'b1          // Variant with 32K internal flash
)
(
  input  wire logic        clk,           // Core clock, 20 MHz
  input  wire logic        rst,           // Synchronous reset, active high
  input  wire logic        por,           // Power-on load of nonvolatile cells
  input  wire logic [7:0]  addr,          // Register byte address
  input  wire logic [31:0] wdata,         // Register write data
  input  wire logic        wr,            // Write strobe
  input  wire logic        rd,            // Read strobe
  output logic      [31:0] rdata,         // Read data, one cycle after rd
  input  wire logic        external_access_pin, // Fetch source pin
  input  wire logic [15:0] pc,            // Program counter from core
  output logic             fetch_external,// Fetch from external memory
  output logic             grant,         // One-cycle pulse, access granted
  output logic             refuse,        // One-cycle pulse, access refused
  output logic      [7:0]  answer         // Bootloader answer character
);

  // Full state of the block
  typedef struct packed
  {
    logic [7:0]  software_security_byte; // Nonvolatile level cell
    logic        lock_bit_first;         // Nonvolatile, zero is programmed
    logic        lock_bit_second;        // Nonvolatile, zero is programmed
    fsag_state_t state;                  // Command engine
    fsag_req_t   req;                    // Captured request
    logic        granted;                // Sticky outcome flags
    logic        refused;                // Sticky outcome flags
    logic        overrun;                // Command lost while busy
    logic [7:0]  read_value;             // Value read by last command, zero unless a granted security byte or lock read
    logic [7:0]  answer;                 // Answer character
    logic        grant;                  // Grant pulse
    logic        refuse;                 // Refuse pulse
    logic        fetch_external;         // Fetch source
    logic [31:0] rdata;                  // Read data register
  } fsag_regs_t;

  // Reset image of the whole state
  localparam fsag_regs_t REGS_INIT = '{
    software_security_byte: SSB_LEVEL0,
    lock_bit_first:         LOCK_BLANK[0],
    lock_bit_second:        LOCK_BLANK[1],
    state:                  ST_IDLE,
    req:                    '0,
    granted:                1'b0,
    refused:                1'b0,
    overrun:                1'b0,
    read_value:             8'h00,
    answer:                 ANS_OK,
    grant:                  1'b0,
    refuse:                 1'b0,
    fetch_external:         1'b0,
    rdata:                  32'h0000_0000
  };

  // Highest internal address of this variant
  localparam logic [15:0] FLASH_TOP = FLASH_32K ? FLASH_TOP_32K : FLASH_TOP_16K; // R12

  fsag_regs_t  r;            // Registered state
  fsag_regs_t  next_r;       // Next state
  logic        pin_sync;     // Synchronised access pin
  fsag_level_t level;        // Decoded security level
  logic        mem_class;    // Target is flash, fuse, boot byte or lock
  logic        ok;           // Decision of the check
  logic [7:0]  code;         // Refusal character

  // Access pin passes two flops first
  fsag_sync
  #(
    .W (1)
  )
  u_pin_sync
  (
    .clk (clk),
    .rst (rst),
    .d   (external_access_pin),
    .q   (pin_sync)
  );

  // Decode level; a cleared bit 1 counts as level two whatever bit 0 holds
  always_comb
  begin
    if (!r.software_security_byte[1])
    begin
      level = LVL_2;
    end
    else if (!r.software_security_byte[0])
    begin
      level = LVL_1;
    end
    else
    begin
      level = LVL_0;
    end
  end

  // Targets guarded like the flash array
  always_comb
  begin
    unique case (r.req.target)
      TGT_FLASH, TGT_FUSE, TGT_BOOT_STAT, TGT_BOOT_VEC, TGT_LOCK: mem_class = 1'b1;
      default: mem_class = 1'b0;
    endcase
  end

  // Permission check of the captured request
  always_comb
  begin
    ok   = 1'b1;
    code = ANS_OK;
    unique case (r.req.op)
      OP_CHIP_ERASE, OP_BLANK_CHECK:
      begin
        ok = 1'b1; // R08
      end
      OP_BLOCK_ERASE:
      begin
        // Only at level zero
        if (level != LVL_0)
        begin
          ok   = 1'b0; // R08
          code = (level == LVL_2) ? ANS_LOCK : ANS_PROT;
        end
      end
      OP_READ:
      begin
        if (mem_class && level == LVL_2)
        begin
          ok   = 1'b0; // R04 R06
          code = ANS_LOCK;
        end
        else if (r.req.target == TGT_SSB && level == LVL_1)
        begin
          ok   = 1'b0; // R07
          code = ANS_PROT;
        end
      end
      OP_WRITE:
      begin
        if (r.req.target == TGT_MANUF || r.req.target == TGT_BOOT_INFO)
        begin
          ok   = 1'b0; // R08
          code = ANS_PROT;
        end
        else if (mem_class && level == LVL_2)
        begin
          ok   = 1'b0; // R04 R06
          code = ANS_LOCK;
        end
        else if (mem_class && level == LVL_1)
        begin
          ok   = 1'b0; // R03 R06
          code = ANS_PROT;
        end
        else if (r.req.target == TGT_SSB)
        begin
          // Only an encoded level above the present one
          if (level == LVL_2)
          begin
            ok   = 1'b0; // R07
            code = ANS_LOCK;
          end
          else if (r.req.data == SSB_LEVEL2)
          begin
            ok = 1'b1; // R02 R07
          end
          else if (r.req.data == SSB_LEVEL1 && level == LVL_0)
          begin
            ok = 1'b1; // R02
          end
          else
          begin
            ok   = 1'b0; // R02
            code = ANS_PROT;
          end
        end
      end
      default:
      begin
        // Unused operation code
        ok   = 1'b0;
        code = ANS_PROT;
      end
    endcase

    // Lock bits guard the flash array over the in-system port only
    if (ok && r.req.isp && r.req.target == TGT_FLASH)
    begin
      if (!r.lock_bit_second && r.req.op == OP_READ)
      begin
        ok   = 1'b0; // R10
        code = ANS_LOCK;
      end
      else if ((!r.lock_bit_first || !r.lock_bit_second) &&
               (r.req.op == OP_WRITE || r.req.op == OP_BLOCK_ERASE))
      begin
        ok   = 1'b0; // R09 R10
        code = ANS_PROT;
      end
    end
  end

  // Next state of the whole block
  always_comb
  begin
    next_r        = r;
    next_r.grant  = 1'b0;
    next_r.refuse = 1'b0;
    next_r.rdata  = 32'h0000_0000;

    // Fetch source from pin and counter
    next_r.fetch_external = !pin_sync || (pc > FLASH_TOP); // R13 R14

    // Command engine
    unique case (r.state)
      ST_IDLE:
      begin
        // Take a new command
        if (wr && addr == REG_CMD)
        begin
          next_r.req.op     = fsag_op_t'(wdata[CMD_OP_LSB +: 3]);
          next_r.req.target = fsag_target_t'(wdata[CMD_TGT_LSB +: 3]);
          next_r.req.isp    = wdata[CMD_ISP_BIT];
          next_r.req.data   = wdata[CMD_DATA_LSB +: 8];
          next_r.granted    = 1'b0;
          next_r.refused    = 1'b0;
          next_r.overrun    = 1'b0;
          next_r.state      = ST_CHECK;
        end
      end
      ST_CHECK:
      begin
        // Apply the decision
        next_r.state = ST_ANSWER;
        if (ok)
        begin
          next_r.granted = 1'b1;
          next_r.answer  = ANS_OK;
          next_r.grant   = 1'b1;
          if (r.req.op == OP_CHIP_ERASE)
          begin
            // Erase returns cells to blank
            next_r.software_security_byte = SSB_LEVEL0;      // R05
            next_r.lock_bit_first         = LOCK_BLANK[0];   // R05
            next_r.lock_bit_second        = LOCK_BLANK[1];   // R05
          end
          else if (r.req.op == OP_WRITE && r.req.target == TGT_SSB)
          begin
            next_r.software_security_byte = r.req.data;      // R02
          end
          else if (r.req.op == OP_WRITE && r.req.target == TGT_LOCK)
          begin
            // Programming only clears bits
            next_r.lock_bit_first  = r.lock_bit_first & r.req.data[0];
            next_r.lock_bit_second = r.lock_bit_second & r.req.data[1];
          end
          // Capture what a read returns
          if (r.req.op == OP_READ && r.req.target == TGT_SSB)
          begin
            next_r.read_value = r.software_security_byte;
          end
          else if (r.req.op == OP_READ && r.req.target == TGT_LOCK)
          begin
            next_r.read_value = {6'h00, r.lock_bit_second, r.lock_bit_first};
          end
          else
          begin
            next_r.read_value = 8'h00;
          end
        end
        else
        begin
          next_r.refused    = 1'b1;
          next_r.answer     = code; // R03 R04
          next_r.refuse     = 1'b1;
          next_r.read_value = 8'h00;
        end
      end
      ST_ANSWER:
      begin
        // Back to idle for the next command
        next_r.state = ST_IDLE;
      end
      default:
      begin
        next_r.state = ST_IDLE;
      end
    endcase

    // Command lost while engine busy
    if (wr && addr == REG_CMD && r.state != ST_IDLE)
    begin
      next_r.overrun = 1'b1;
    end

    // Register reads, data stand one cycle later
    if (rd)
    begin
      unique case (addr)
        REG_CMD:
        begin
          next_r.rdata[CMD_OP_LSB +: 3]   = r.req.op;
          next_r.rdata[CMD_TGT_LSB +: 3]  = r.req.target;
          next_r.rdata[CMD_ISP_BIT]       = r.req.isp;
          next_r.rdata[CMD_DATA_LSB +: 8] = r.req.data;
        end
        REG_RESULT:
        begin
          next_r.rdata[RES_ANS_LSB +: 8]  = r.answer;
          next_r.rdata[RES_GRANT]         = r.granted;
          next_r.rdata[RES_REFUSE]        = r.refused;
          next_r.rdata[RES_BUSY]          = (r.state != ST_IDLE);
          next_r.rdata[RES_OVERRUN]       = r.overrun;
          next_r.rdata[RES_DATA_LSB +: 8] = r.read_value;
        end
        REG_STATE:
        begin
          next_r.rdata[STA_SSB_LSB +: 8]  = r.software_security_byte;
          next_r.rdata[STA_LOCK_LSB]      = r.lock_bit_first;
          next_r.rdata[STA_LOCK_LSB + 1]  = r.lock_bit_second;
          next_r.rdata[STA_LVL_LSB +: 2]  = level;
          next_r.rdata[STA_FEXT]          = r.fetch_external;
          next_r.rdata[STA_PIN]           = pin_sync;
        end
        default:
        begin
          // Unmapped reads return zero
          next_r.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // State register; reset keeps the nonvolatile cells
  always_ff @(posedge clk)
  begin
    if (por)
    begin
      r <= REGS_INIT; // R01
    end
    else if (rst)
    begin
      r                        <= REGS_INIT;
      r.software_security_byte <= r.software_security_byte; // R15
      r.lock_bit_first         <= r.lock_bit_first;         // R15
      r.lock_bit_second        <= r.lock_bit_second;        // R15
    end
    else
    begin
      r <= next_r;
    end
  end

  // Outputs straight from the state
  assign rdata          = r.rdata;
  assign fetch_external = r.fetch_external;
  assign grant          = r.grant;
  assign refuse         = r.refuse;
  assign answer         = r.answer;

endmodule

// file: fsag_assertions.sv
// Checker for the flash access guard, bound to its top module.
// Assumes the command timing and fetch latency of the guard's port contract.
`timescale 1ns/1ps

module fsag_assertions
  import fsag_pkg::*;
#(
  parameter bit FLASH_32K = 1'b1                  // Variant with 32K flash
)
(
  input wire logic        clk,                    // Core clock
  input wire logic        rst,                    // Sync reset
  input wire logic        por,                    // Power-on load
  input wire logic [7:0]  addr,                   // Register address
  input wire logic [31:0] wdata,                  // Write data
  input wire logic        wr,                     // Write strobe
  input wire logic        rd,                     // Read strobe
  input wire logic [31:0] rdata,                  // Read data
  input wire logic        external_access_pin,    // Fetch source pin
  input wire logic [15:0] pc,                     // Program counter
  input wire logic        fetch_external,         // Fetch external
  input wire logic        grant,                  // Granted pulse
  input wire logic        refuse,                 // Refused pulse
  input wire logic [7:0]  answer                  // Answer character
);
  logic [1:0]  busy_cnt;  // Cycles left in the engine
  logic        taken;     // Command accepted now
  logic [15:0] top;       // Last internal address

  assign taken = wr && (addr == REG_CMD) && (busy_cnt == 2'h0);
  assign top   = FLASH_32K ? FLASH_TOP_32K : FLASH_TOP_16K;

  // Engine occupancy, mirrors the three-cycle spacing
  always_ff @(posedge clk)
  begin
    if (rst || por)
      busy_cnt <= 2'h0;
    else if (taken)
      busy_cnt <= 2'h2;
    else if (busy_cnt != 2'h0)
      busy_cnt <= busy_cnt - 2'h1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || por);

  // Steps of one command
  sequence s_take;
    taken;
  endsequence
  sequence s_decide;
    ##2 (grant || refuse);
  endsequence

  AST_ONE_OUTCOME: assert property (!(grant && refuse))
    else $error("grant and refuse together");
  AST_ANSWER_TIME: assert property (s_take |-> s_decide)
    else $error("command got no decision");
  AST_NO_STRAY: assert property ((grant || refuse) |-> $past(taken, 2))
    else $error("decision without command");
  AST_ERASE_ALWAYS: assert property (s_take ##0 (wdata[2:0] inside {OP_CHIP_ERASE, OP_BLANK_CHECK})
    |-> ##2 (grant && answer == ANS_OK)) else $error("erase or blank check refused");
  AST_INFO_RO: assert property (s_take ##0 (wdata[2:0] == OP_WRITE)
    ##0 (wdata[5:3] inside {TGT_MANUF, TGT_BOOT_INFO}) |-> ##2 (refuse && answer == ANS_PROT))
    else $error("info write not refused");
  AST_NO_LOWER: assert property (s_take ##0 (wdata[5:0] == {TGT_SSB, OP_WRITE})
    ##0 (wdata[15:8] == SSB_LEVEL0) |-> ##2 refuse) else $error("level lowered by write");
  AST_REFUSE_CHAR: assert property (refuse |-> (answer == ANS_PROT || answer == ANS_LOCK))
    else $error("refusal without P or L");
  AST_ANSWER_HOLD: assert property (!(grant || refuse) |-> $stable(answer))
    else $error("answer changed between decisions");
  AST_EXT_LOW: assert property (!external_access_pin [*5] |-> fetch_external)
    else $error("internal fetch with pin low");
  AST_EXT_PC: assert property (external_access_pin [*5] |=>
    (fetch_external == ($past(pc) > top))) else $error("fetch source wrong for pc");
endmodule

bind fsag_guard fsag_assertions #(.FLASH_32K(FLASH_32K)) u_chk
(
  .clk(clk), .rst(rst), .por(por), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .external_access_pin(external_access_pin), .pc(pc),
  .fetch_external(fetch_external), .grant(grant), .refuse(refuse), .answer(answer)
);

// file: fsag_prog.sv
// Programmer model: issues commands and reads over the register port.
// Assumes the guard decides two cycles after a taken command.
`timescale 1ns/1ps

module fsag_prog
  import fsag_pkg::*;
(
  input  wire logic        clk,     // Core clock
  output logic      [7:0]  addr,    // Register address
  output logic      [31:0] wdata,   // Write data
  output logic             wr,      // Write strobe
  output logic             rd,      // Read strobe
  input  wire logic [31:0] rdata,   // Read data
  input  wire logic        grant,   // Granted pulse
  input  wire logic        refuse,  // Refused pulse
  input  wire logic [7:0]  answer   // Answer character
);
  // Bus idle at time zero
  initial
  begin
    addr  = 8'h00;
    wdata = 32'h0;
    wr    = 1'b0;
    rd    = 1'b0;
  end

  // One write cycle, data scrambled after release
  task wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    wdata <= ~d;
  endtask

  // One read cycle, data taken in the following cycle
  task rd_reg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  // Command, then the decision two cycles on
  task issue(input logic [31:0] c, output logic g, output logic r, output logic [7:0] a);
    wr_reg(REG_CMD, c);
    @(posedge clk);
    @(posedge clk);
    g = grant;
    r = refuse;
    a = answer;
  endtask
endmodule

// file: testbench.sv
// Self-checking bench for the flash access guard.
// Assumes the programmer model drives the register port.
`timescale 1ns/1ps

module testbench;
  import fsag_pkg::*;

  logic        clk;          // Core clock
  logic        rst;          // Sync reset
  logic        por;          // Power-on load
  logic [7:0]  addr;         // Register address
  logic [31:0] wdata;        // Write data
  logic        wr;           // Write strobe
  logic        rd;           // Read strobe
  logic [31:0] rdata;        // Read data
  logic        pin;          // Fetch source pin
  logic [15:0] pc;           // Program counter
  logic        fext;         // Fetch external
  logic        grant;        // Granted pulse
  logic        refuse;       // Refused pulse
  logic [7:0]  answer;       // Answer character
  logic [31:0] v;            // Read value
  int          err_total;    // Mismatches
  int          comparisons;  // Compares made

  fsag_guard dut (.clk(clk), .rst(rst), .por(por), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .external_access_pin(pin), .pc(pc), .fetch_external(fext),
    .grant(grant), .refuse(refuse), .answer(answer));
  fsag_prog prog (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .grant(grant), .refuse(refuse), .answer(answer));

  // 20 MHz core clock
  always #25 clk = ~clk;

  // Compare and count
  task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask

  // Issue one command, judge the decision
  task ex(input logic [2:0] op, input logic [2:0] tg, input logic isp, input logic [7:0] d,
          input logic ok, input logic [7:0] ans);
    logic       g;
    logic       r;
    logic [7:0] a;
    prog.issue({16'h0, d, 1'b0, isp, tg, op}, g, r, a);
    chk("grant", {31'h0, g}, {31'h0, ok});
    chk("refuse", {31'h0, r}, {31'h0, !ok});
    chk("answer", {24'h0, a}, {24'h0, ans});
  endtask

  // Level, locks and security byte
  task st(input logic [11:0] exp);
    prog.rd_reg(REG_STATE, v);
    chk("state", {20'h0, v[11:0]}, {20'h0, exp});
  endtask

  // Level zero: open, info read-only
  task t_level0;
    st(12'h3FF);
    prog.rd_reg(8'h0C, v);
    chk("unmapped", v, 32'h0);
    for (int t = 0; t < 4; t++)
    begin
      ex(OP_WRITE, 3'(t), 1'b0, 8'hA5, 1'b1, ANS_OK);
      ex(OP_READ, 3'(t), 1'b1, 8'h00, 1'b1, ANS_OK);
    end
    ex(OP_BLOCK_ERASE, TGT_FLASH, 1'b0, 8'h00, 1'b1, ANS_OK);
    ex(OP_WRITE, TGT_MANUF, 1'b0, 8'h00, 1'b0, ANS_PROT);
    ex(OP_READ, TGT_BOOT_INFO, 1'b0, 8'h00, 1'b1, ANS_OK);
    ex(3'h5, TGT_FLASH, 1'b0, 8'h00, 1'b0, ANS_PROT);
  endtask

  // Level one: reads only, byte may go to two
  task t_level1;
    ex(OP_WRITE, TGT_SSB, 1'b0, SSB_LEVEL1, 1'b1, ANS_OK);
    st(12'h7FE);
    for (int t = 0; t < 4; t++)
    begin
      ex(OP_WRITE, 3'(t), 1'b0, 8'h00, 1'b0, ANS_PROT);
      ex(OP_READ, 3'(t), 1'b0, 8'h00, 1'b1, ANS_OK);
    end
    ex(OP_BLOCK_ERASE, TGT_FLASH, 1'b0, 8'h00, 1'b0, ANS_PROT);
    ex(OP_READ, TGT_SSB, 1'b0, 8'h00, 1'b0, ANS_PROT);
    ex(OP_WRITE, TGT_SSB, 1'b0, SSB_LEVEL0, 1'b0, ANS_PROT);
    ex(OP_WRITE, TGT_SSB, 1'b0, SSB_LEVEL1, 1'b0, ANS_PROT);
    ex(OP_WRITE, TGT_SSB, 1'b0, SSB_LEVEL2, 1'b1, ANS_OK);
  endtask

  // Level two: memory access refused, byte readable, survives reset
  task t_level2;
    st(12'hBFC);
    for (int t = 0; t < 4; t++)
    begin
      ex(OP_WRITE, 3'(t), 1'b0, 8'h00, 1'b0, ANS_LOCK);
      ex(OP_READ, 3'(t), 1'b0, 8'h00, 1'b0, ANS_LOCK);
    end
    ex(OP_WRITE, TGT_SSB, 1'b0, SSB_LEVEL2, 1'b0, ANS_LOCK);
    ex(OP_READ, TGT_SSB, 1'b0, 8'h00, 1'b1, ANS_OK);
    prog.rd_reg(REG_RESULT, v);
    chk("result", v, 32'h00FC_0100);
    ex(OP_BLANK_CHECK, TGT_FLASH, 1'b0, 8'h00, 1'b1, ANS_OK);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    st(12'hBFC);
    ex(OP_CHIP_ERASE, TGT_FLASH, 1'b1, 8'h00, 1'b1, ANS_OK);
    st(12'h3FF);
  endtask

  // Lock bits over the in-system port
  task t_locks;
    ex(OP_READ, TGT_FLASH, 1'b1, 8'h00, 1'b1, ANS_OK);
    ex(OP_WRITE, TGT_LOCK, 1'b0, 8'h02, 1'b1, ANS_OK);
    st(12'h2FF);
    ex(OP_WRITE, TGT_FLASH, 1'b1, 8'h00, 1'b0, ANS_PROT);
    ex(OP_READ, TGT_FLASH, 1'b1, 8'h00, 1'b1, ANS_OK);
    ex(OP_CHIP_ERASE, TGT_FLASH, 1'b0, 8'h00, 1'b1, ANS_OK);
    ex(OP_WRITE, TGT_LOCK, 1'b0, 8'h01, 1'b1, ANS_OK);
    ex(OP_READ, TGT_FLASH, 1'b1, 8'h00, 1'b0, ANS_LOCK);
    ex(OP_WRITE, TGT_FLASH, 1'b1, 8'h00, 1'b0, ANS_PROT);
    // Reset long enough that the cleared answer has settled before release
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    st(12'h1FF);
    ex(OP_CHIP_ERASE, TGT_FLASH, 1'b0, 8'h00, 1'b1, ANS_OK);
  endtask

  // Fetch source against pin and counter
  task t_fetch;
    pc <= 16'h7FFF;
    repeat (2) @(posedge clk);
    chk("fetch 7FFF", {31'h0, fext}, 32'h0);
    pc <= 16'h8000;
    repeat (2) @(posedge clk);
    chk("fetch 8000", {31'h0, fext}, 32'h1);
    pin <= 1'b0;
    pc  <= 16'h0000;
    repeat (5) @(posedge clk);
    chk("fetch pin low", {31'h0, fext}, 32'h1);
    pin <= 1'b1;
  endtask

  // Second command while busy is dropped
  task t_overrun;
    prog.wr_reg(REG_CMD, {29'h0, OP_BLANK_CHECK});
    prog.wr_reg(REG_CMD, {29'h0, OP_BLOCK_ERASE});
    prog.rd_reg(REG_RESULT, v);
    chk("overrun", v, 32'h0000_0900);
  endtask

  // Verdict and end of run
  task report_and_stop;
    if (err_total == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop;
  end

  // Power-on, then each scenario
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    por = 1'b1;
    pin = 1'b1;
    pc = 16'h0000;
    err_total = 0;
    comparisons = 0;
    repeat (20) @(posedge clk);
    por <= 1'b0;
    rst <= 1'b0;
    t_level0;
    t_level1;
    t_level2;
    t_locks;
    t_fetch;
    t_overrun;
    report_and_stop;
  end
endmodule
